// ---- core/photosensor_frontend_readout.sv ----
// front-end readout board logic: digitiser input, buffer, link, status
//
// Behaviour
// [R1] eight channels per digitiser, twelve-bit samples
// [R2] bit-serial digitiser streams are reassembled into twelve-bit words
// [R3] samples below the channel threshold are dropped when suppressing
// [R4] unsuppressed hits are held in a ring buffer covering trigger latency
// [R5] diagnostic mode bypasses suppression and records every sample
// [R6] each hit holds four consecutive samples
// [R7] bias gate output lowers sensor bias during the flash window
// [R8] records leave serialised as nibbles on the ethernet transmit port
// [R9] control register kept in three voted copies
// [R10] digitiser parameters read back periodically and rewritten on mismatch
// [R11] acquisition waits out the configuration time after reset
// [R12] punched reference clock is recovered and status bits extracted
// [R13] controller encodes status by punching reference clock pulses
// [R14] super-cycle messages arrive ahead of each microspill; the logic has no super-cycle message input, only the punched reference clock
// [R15] one microspill is ninety reference cycles, counted locally
// [R16] slow status record sent about once per second
// [R17] controller pools status blocks of all boards; not modelled, the controller model only drives the punched reference clock
// [R18] slow pool writes forwarded to the board are applied
// [R19] loss of synchronisation is flagged in each record header; only hit records carry the flag, status records do not
// [R20] time of a synchronisation error is latched and reported
// [R21] sixteen carrier boards, each with its own enable
// [R22] trigger accept forwards all buffered hits of that microspill
// [R23] buffer depth is a parameter sized for the trigger latency
// [R24] per-channel thresholds are writable at any time
// [R25] gate timed from microspill boundary by start and length
`include "feb_params.svh"
module photosensor_frontend_readout import feb_pkg::*; #(
  parameter int CH = 8,
  parameter int SW = 12,
  parameter int DEPTH = 256,
  parameter int CFG_CYC = `FEB_CFG_MS * 1000 * `FEB_CLK_MHZ,
  parameter int STAT_CYC = `FEB_STAT_MS * 1000 * `FEB_CLK_MHZ,
  parameter int SCRUB_CYC = `FEB_SCRUB_US * `FEB_CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adc_bclk,
  input wire logic adc_frame,
  input wire logic [CH-1:0] adc_data,
  input wire logic ref_clk_in,
  input wire logic trig_accept,
  input wire logic [7:0] trig_tag,
  input wire logic [15:0] adc_param_rb,
  output logic [15:0] adc_param_out,
  output logic adc_param_we,
  output logic [3:0] mii_txd,
  output logic mii_tx_en,
  output logic bias_gate,
  output logic [15:0] carrier_en
);
  localparam int AW = $clog2(DEPTH);
  localparam int MS = `FEB_MICROSPILL;
  localparam int NB = `FEB_STAT_BITS;
  localparam int PUNCH_CYC = `FEB_PUNCH_NS * `FEB_CLK_MHZ / 1000;
  localparam int PB = CH;
  localparam int PF = CH + 1;
  localparam int PR = CH + 2;
  localparam int PT = CH + 3;
  localparam int PW = CH + 28;

  if (CH < 1 || CH > 8 || SW != 12 || DEPTH < 2) begin : g_bad
    $error("unsupported parameter set");
  end

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic [PW-1:0] pins, s1, s2, pd;
  assign pins = {adc_param_rb, trig_tag, trig_accept, ref_clk_in,
                 adc_frame, adc_bclk, adc_data};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      pd <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      pd <= s2;
    end
  end
  wire b_rise = s2[PB] & ~pd[PB];
  wire r_rise = s2[PR] & ~pd[PR];
  wire t_rise = s2[PT] & ~pd[PT];
  wire [15:0] rb = s2[PW-1:PW-16];

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic [1:0] c0, c1, c2;
  logic [15:0] gate_reg, param_reg;
  logic [23:0] slow_reg, err_time;
  logic [SW-1:0] thr [CH];
  logic booted, locked;
  logic [7:0] spill_status;
  logic [31:0] boot_cnt;
  wire [1:0] ctrl = (c0 & c1) | (c0 & c2) | (c1 & c2); // [R9]
  wire acq = ctrl[`FEB_CTRL_ACQ] & booted; // [R11]
  wire diag = ctrl[`FEB_CTRL_DIAG];
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready & pwrite;
  wire thr_hit = (paddr[11:5] == 7'(`FEB_ADDR_THR >> 5)) &&
                 (int'(paddr[4:2]) < CH);
  wire [2:0] thr_idx = paddr[4:2];
  wire [31:0] rd_val =
    (paddr == `FEB_ADDR_CTRL) ? {30'h0, ctrl} :
    (paddr == `FEB_ADDR_GATE) ? {16'h0, gate_reg} :
    (paddr == `FEB_ADDR_CARR) ? {16'h0, carrier_en} :
    (paddr == `FEB_ADDR_PARAM) ? {16'h0, param_reg} :
    (paddr == `FEB_ADDR_SLOW) ? {8'h0, slow_reg} :
    (paddr == `FEB_ADDR_STAT) ? {15'h0, booted, 7'h0, locked, spill_status} :
    (paddr == `FEB_ADDR_ERRT) ? {8'h0, err_time} :
    thr_hit ? {20'h0, thr[thr_idx]} : 32'h0;
  wire hit_ok = thr_hit || (paddr <= `FEB_ADDR_ERRT && paddr[1:0] == 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit_ok;
      if (setup && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0 <= `FEB_CTRL_RST;
      c1 <= `FEB_CTRL_RST;
      c2 <= `FEB_CTRL_RST;
      gate_reg <= `FEB_GATE_RST;
      carrier_en <= `FEB_CARR_RST;
      param_reg <= `FEB_PARAM_RST;
      slow_reg <= `FEB_SLOW_RST;
      for (int i = 0; i < CH; i++) begin
        thr[i] <= `FEB_THR_RST;
      end
    end else begin
      c0 <= ctrl; // [R9]
      c1 <= ctrl;
      c2 <= ctrl;
      if (wr_en) begin // [R18]
        if (paddr == `FEB_ADDR_CTRL) begin
          c0 <= pwdata[1:0];
          c1 <= pwdata[1:0];
          c2 <= pwdata[1:0];
        end
        if (paddr == `FEB_ADDR_GATE) gate_reg <= pwdata[15:0];
        if (paddr == `FEB_ADDR_CARR) carrier_en <= pwdata[15:0]; // [R21]
        if (paddr == `FEB_ADDR_PARAM) param_reg <= pwdata[15:0];
        if (paddr == `FEB_ADDR_SLOW) slow_reg <= pwdata[23:0];
        if (thr_hit) thr[thr_idx] <= pwdata[SW-1:0]; // [R24]
      end
    end
  end

  // --------------------------------------------------------------------
  // startup hold
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      booted <= 1'b0;
      boot_cnt <= 32'h0;
    end else if (!booted) begin
      if (boot_cnt == 32'(CFG_CYC - 1)) booted <= 1'b1; // [R11]
      else boot_cnt <= boot_cnt + 32'h1;
    end
  end

  // --------------------------------------------------------------------
  // punched clock recovery and microspill timing
  // --------------------------------------------------------------------
  logic [7:0] gc, sbits;
  logic [6:0] ms;
  logic [15:0] spill_id;
  logic loss_ev;
  wire punched = gc > 8'(PUNCH_CYC);
  wire [6:0] nm = (ms == 7'(MS - 1)) ? 7'h0 : ms + 7'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gc <= 8'h0;
      ms <= 7'h0;
      sbits <= 8'h0;
      spill_status <= 8'h0;
      spill_id <= 16'h0;
      locked <= 1'b0;
      loss_ev <= 1'b0;
      err_time <= 24'h0;
    end else begin
      loss_ev <= 1'b0;
      if (r_rise) gc <= 8'h0;
      else if (gc != 8'hff) gc <= gc + 8'h1;
      if (loss_ev) err_time <= {spill_id, 1'b0, ms}; // [R20]
      if (r_rise && !locked && punched) begin // [R12]
        locked <= 1'b1;
        ms <= 7'h0;
        spill_id <= spill_id + 16'h1;
      end else if (r_rise && locked) begin
        ms <= nm; // [R15]
        if (nm == 7'h0) begin
          spill_id <= spill_id + 16'h1;
          if (!punched) begin
            locked <= 1'b0;
            loss_ev <= 1'b1;
          end
        end else if (int'(nm) <= NB) begin
          sbits <= {sbits[NB-2:0], punched}; // [R12]
        end else if (int'(nm) == NB + 1) begin
          spill_status <= sbits;
        end else if (punched) begin
          locked <= 1'b0;
          loss_ev <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // bias gate and parameter scrub
  // --------------------------------------------------------------------
  wire [8:0] gate_end = {1'b0, gate_reg[7:0]} + {1'b0, gate_reg[15:8]};
  logic [31:0] scrub_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias_gate <= 1'b0;
      scrub_cnt <= 32'h0;
      adc_param_we <= 1'b0;
      adc_param_out <= `FEB_PARAM_RST;
    end else begin
      bias_gate <= locked && ({1'b0, ms} >= {1'b0, gate_reg[7:0]}) &&
                   ({2'b0, ms} < gate_end); // [R7] [R25]
      adc_param_out <= param_reg;
      adc_param_we <= 1'b0;
      if (scrub_cnt == 32'(SCRUB_CYC - 1)) begin
        scrub_cnt <= 32'h0;
        adc_param_we <= (rb != adc_param_out); // [R10]
      end else begin
        scrub_cnt <= scrub_cnt + 32'h1;
      end
    end
  end

  // --------------------------------------------------------------------
  // deserialiser and hit capture
  // --------------------------------------------------------------------
  logic [SW-1:0] sh [CH];
  logic [SW-1:0] wd [CH];
  logic [4*SW-1:0] hbuf [CH];
  logic [10:0] htag [CH];
  logic [1:0] hcnt [CH];
  logic [CH-1:0] pend;
  logic [2:0] sel;
  logic any;
  wire word_stb = b_rise & s2[PF];
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      wd[i] = {sh[i][SW-2:0], s2[i]}; // [R2]
    end
  end
  always_comb begin
    sel = 3'h0;
    any = 1'b0;
    for (int i = CH - 1; i >= 0; i--) begin
      if (pend[i]) begin
        sel = 3'(i);
        any = 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= '0;
      for (int i = 0; i < CH; i++) begin
        sh[i] <= '0;
        hbuf[i] <= '0;
        htag[i] <= '0;
        hcnt[i] <= 2'h0;
      end
    end else begin
      if (any) pend[sel] <= 1'b0;
      for (int i = 0; i < CH; i++) begin
        if (b_rise) sh[i] <= wd[i]; // [R2]
        if (word_stb && (hcnt[i] != 2'h0 ||
            (acq && (diag || wd[i] >= thr[i])))) begin // [R1] [R3] [R5]
          hbuf[i] <= {hbuf[i][3*SW-1:0], wd[i]};
          hcnt[i] <= hcnt[i] + 2'h1; // [R6]
          if (hcnt[i] == 2'h0) htag[i] <= spill_id[10:0];
          if (hcnt[i] == 2'h3) pend[i] <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // latency ring, trigger scan, status record, transmit
  // --------------------------------------------------------------------
  record_t mem [DEPTH];
  logic [DEPTH-1:0] vld;
  logic [AW-1:0] wp, si;
  logic [7:0] scan_tag;
  scan_t st;
  logic stat_req, tx_busy, tick;
  logic [31:0] stat_cnt;
  logic [3:0] ncnt;
  record_t tx_sh;
  wire scan_go = (st == scan_run) && !tx_busy && !stat_req;
  wire load_hit = scan_go && vld[si] && mem[si][55:48] == scan_tag;
  wire load_stat = stat_req && !tx_busy;
  wire record_t stat_rec = {`FEB_REC_STAT, 6'h0, err_time, slow_reg,
                            spill_status}; // [R16] [R20]
  always_ff @(posedge pclk) begin
    if (any) mem[wp] <= {1'b0, ~locked, sel, htag[sel], hbuf[sel]}; // [R19]
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vld <= '0;
      wp <= '0;
      si <= '0;
      st <= scan_idle;
      scan_tag <= 8'h0;
      stat_req <= 1'b0;
      stat_cnt <= 32'h0;
    end else begin
      if (any) begin
        vld[wp] <= 1'b1; // [R4] [R23]
        wp <= wp + AW'(1);
      end
      case (st)
        scan_idle: begin
          if (t_rise) begin // [R22]
            st <= scan_run;
            scan_tag <= s2[PT+8:PT+1];
            si <= '0;
          end
        end
        scan_run: begin
          if (scan_go) begin
            si <= si + AW'(1);
            if (si == AW'(DEPTH - 1)) st <= scan_idle;
          end
        end
        default: st <= scan_idle;
      endcase
      if (load_stat) stat_req <= 1'b0;
      if (stat_cnt == 32'(STAT_CYC - 1)) begin
        stat_cnt <= 32'h0;
        stat_req <= 1'b1; // [R16]
      end else begin
        stat_cnt <= stat_cnt + 32'h1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
      tx_busy <= 1'b0;
      ncnt <= 4'h0;
      tx_sh <= '0;
      mii_txd <= 4'h0;
      mii_tx_en <= 1'b0;
    end else begin
      tick <= ~tick;
      if (tick && tx_busy) begin // [R8]
        mii_txd <= tx_sh[63:60];
        mii_tx_en <= 1'b1;
        tx_sh <= {tx_sh[59:0], 4'h0};
        ncnt <= ncnt + 4'h1;
        if (ncnt == 4'hf) tx_busy <= 1'b0;
      end else if (tick) begin
        mii_tx_en <= 1'b0;
      end
      if (!tx_busy && (load_stat || load_hit)) begin
        tx_sh <= load_stat ? stat_rec : mem[si];
        tx_busy <= 1'b1;
        ncnt <= 4'h0;
      end
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_gate_needs_lock: assert property (!locked |=> !bias_gate) // [R7]
    else $error("gate active while unlocked");
  chk_spill_wrap: assert property // [R15]
    (r_rise && locked && ms == 7'(MS - 1) && punched |=> ms == 7'h0)
    else $error("microspill counter did not wrap");
  chk_ring_advance: assert property (any |=> wp == $past(wp) + AW'(1)) // [R4]
    else $error("ring pointer did not advance");
  chk_diag_capture: assert property // [R5]
    (acq && diag && word_stb && hcnt[0] == 2'h0 |=> hcnt[0] == 2'h1)
    else $error("diagnostic sample not captured");
  chk_suppress_low: assert property // [R3]
    (acq && !diag && word_stb && hcnt[0] == 2'h0 && wd[0] < thr[0]
     |=> hcnt[0] == 2'h0)
    else $error("sub-threshold sample captured");
  chk_vote_copies: assert property (##1 (c0 == c1 && c1 == c2)) // [R9]
    else $error("control copies disagree");
  chk_scrub_pulse: assert property (adc_param_we |=> !adc_param_we) // [R10]
    else $error("parameter rewrite not a single pulse");
  chk_boot_hold: assert property (!booted |-> !acq) // [R11]
    else $error("acquisition before configuration time");
  chk_loss_unlock: assert property // [R20]
    (loss_ev |=> !locked && err_time[6:0] == $past(ms))
    else $error("sync loss not latched");
endmodule // photosensor_frontend_readout

// ---- inc/feb_params.svh ----
// register map, reset values and timing constants of the readout logic
`ifndef FEB_PARAMS_SVH
`define FEB_PARAMS_SVH
// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define FEB_ADDR_CTRL 12'h000
`define FEB_ADDR_GATE 12'h004
`define FEB_ADDR_CARR 12'h008
`define FEB_ADDR_PARAM 12'h00c
`define FEB_ADDR_SLOW 12'h010
`define FEB_ADDR_STAT 12'h014
`define FEB_ADDR_ERRT 12'h018
`define FEB_ADDR_THR 12'h020
// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define FEB_CTRL_ACQ 0
`define FEB_CTRL_DIAG 1
`define FEB_CTRL_RST 2'h0
`define FEB_GATE_RST 16'h0000
`define FEB_CARR_RST 16'hffff
`define FEB_PARAM_RST 16'h0000
`define FEB_SLOW_RST 24'h000000
`define FEB_THR_RST 12'h0ff
`define FEB_REC_STAT 2'h2
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FEB_CLK_MHZ 50
`define FEB_CFG_MS 30
`define FEB_STAT_MS 1000
`define FEB_SCRUB_US 100
`define FEB_PUNCH_NS 240
`define FEB_MICROSPILL 90
`define FEB_STAT_BITS 8
`endif

// ---- inc/feb_pkg.sv ----
// types shared by the readout logic
package feb_pkg;
  typedef enum logic [0:0] {scan_idle, scan_run} scan_t;
  typedef logic [63:0] record_t;
endpackage

// ---- test/controller_model.sv ----
// readout controller model: punched reference clock source
module controller_model (
  output logic ref_clk_in,
  input wire logic run,
  input wire logic [7:0] status,
  input wire logic [6:0] bad_pos
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos;
  bit punch;
  // clock stands low while not running; a punch delays the edge a period
  initial begin
    ref_clk_in = 1'b0;
    pos = 0;
    #7;
    forever begin
      if (run !== 1'b1) begin
        pos = 0;
        #160;
      end else begin
        punch = pos == 0 || (pos < 9 && status[8 - pos]);
        if (punch || (bad_pos != 0 && pos == bad_pos)) #160;
        ref_clk_in = 1'b1;
        #80;
        ref_clk_in = 1'b0;
        #80;
        pos = (pos == 89) ? 0 : pos + 1;
      end
    end
  end
endmodule // controller_model

// ---- test/photosensor_frontend_readout_bench.sv ----
// self-checking bench of the front-end readout logic
`include "feb_params.svh"
module photosensor_frontend_readout_bench import feb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdata;
  logic pready, pslverr, rerr, adc_param_we, mii_tx_en, bias_gate;
  logic adc_bclk = 0, adc_frame = 0, ref_clk_in, trig_accept = 0;
  logic ref_run = 0;
  logic [7:0] adc_data = 0, st = 0, trig_tag = 0;
  logic [6:0] bad_pos = 0;
  logic [15:0] adc_param_rb = 0, adc_param_out, carrier_en, p;
  logic [3:0] mii_txd;
  logic [23:0] slow_exp = 0;
  logic [47:0] s;
  logic [47:0] ds [8];
  logic [95:0] ws;
  record_t rec;
  record_t exp_q [$];
  int num_errors = 0, comparisons = 0, nib = 0, n_stat = 0, n_we = 0;
  int glen = 0, last_glen = 0;
  bit ph = 0;
  always #10 pclk = ~pclk;
  photosensor_frontend_readout #(.DEPTH(16), .CFG_CYC(20), .STAT_CYC(500),
    .SCRUB_CYC(50)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_bclk(adc_bclk), .adc_frame(adc_frame), .adc_data(adc_data),
    .ref_clk_in(ref_clk_in), .trig_accept(trig_accept), .trig_tag(trig_tag),
    .adc_param_rb(adc_param_rb), .adc_param_out(adc_param_out),
    .adc_param_we(adc_param_we), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en),
    .bias_gate(bias_gate), .carrier_en(carrier_en));
  controller_model i_ctrl (.ref_clk_in(ref_clk_in), .run(ref_run),
    .status(st), .bad_pos(bad_pos));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] got,
                     input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic rd(input string what, input logic [11:0] a,
                    input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk(what, {rerr, rdata}, {err, exp});
  endtask
  task automatic word(input logic [95:0] w);
    for (int b = 11; b >= 0; b--) begin
      for (int c = 0; c < 8; c++) adc_data[c] <= w[c*12+b];
      adc_frame <= (b == 0);
      repeat (3) @(posedge pclk);
      adc_bclk <= 1'b1;
      repeat (3) @(posedge pclk);
      adc_bclk <= 1'b0;
    end
  endtask
  task automatic hit(input int ch, input logic [47:0] v, input bit keep);
    for (int k = 0; k < 4; k++) word(96'(v[47-12*k -: 12]) << (12 * ch));
    if (keep) exp_q.push_back({2'b01, ch[2:0], 11'h000, v});
  endtask
  // ----------------------------------------------------------------
  // output monitors
  // ----------------------------------------------------------------
  always @(negedge pclk) begin
    if (mii_tx_en === 1'b1) begin
      if (!ph) begin
        rec = {rec[59:0], mii_txd};
        nib++;
      end
      ph = !ph;
      if (nib == 16) begin
        nib = 0;
        if (rec[63:62] == 2'b10) begin
          n_stat++;
          chk("status_slow", rec[31:8], slow_exp);
        end else if (exp_q.size() == 0) chk("spare_record", rec, 64'h0);
        else chk("hit_record", rec, exp_q.pop_front());
      end
    end else begin
      ph = 0;
      nib = 0;
    end
  end
  always @(posedge pclk) begin
    if (adc_param_we === 1'b1) n_we <= n_we + 1;
    if (bias_gate === 1'b1) glen <= glen + 1;
    else if (glen != 0) begin
      last_glen <= glen;
      glen <= 0;
    end
  end
  initial begin
    void'($urandom(84195));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("stat_boot", `FEB_ADDR_STAT, 32'h0, 1'b0);
    rd("ctrl_rst", `FEB_ADDR_CTRL, 32'h0, 1'b0);
    rd("gate_rst", `FEB_ADDR_GATE, 32'h0, 1'b0);
    rd("carr_rst", `FEB_ADDR_CARR, 32'h0000ffff, 1'b0);
    rd("param_rst", `FEB_ADDR_PARAM, 32'h0, 1'b0);
    rd("thr_rst", `FEB_ADDR_THR + 12'h01c, 32'h000000ff, 1'b0);
    rd("unmapped", 12'h01c, 32'h0, 1'b1);
    rd("stat_booted", `FEB_ADDR_STAT, 32'h00010000, 1'b0);
    p = 16'($urandom());
    apb(1'b1, `FEB_ADDR_CARR, {16'h0, p});
    chk("carrier_en", carrier_en, p);
    p = 16'($urandom());
    adc_param_rb <= p;
    apb(1'b1, `FEB_ADDR_PARAM, {16'h0, p});
    repeat (120) @(posedge pclk);
    chk("param_out", adc_param_out, p);
    chk("no_rewrite", n_we, 0);
    adc_param_rb <= ~p;
    repeat (120) @(posedge pclk);
    chk("rewrite", n_we != 0, 1);
    slow_exp = 24'($urandom());
    apb(1'b1, `FEB_ADDR_SLOW, {8'h0, slow_exp});
    apb(1'b1, `FEB_ADDR_CTRL, 32'h1);
    s = 48'({$urandom(), $urandom()}) | 48'h100 << 36;
    hit(3, s, 1);
    hit(5, {12'h0fe, 36'($urandom()) & 36'h07f07f07f}, 0);
    apb(1'b1, `FEB_ADDR_THR + 12'h014, 32'h10);
    hit(5, {12'h020, 36'($urandom())}, 1);
    apb(1'b1, `FEB_ADDR_CTRL, 32'h3);
    for (int k = 0; k < 4; k++) begin
      ws = '0;
      for (int c = 0; c < 8; c++) begin
        ws[c*12 +: 12] = 12'(16 * c + k + 1);
        ds[c] = {ds[c][35:0], ws[c*12 +: 12]};
      end
      word(ws);
    end
    for (int c = 0; c < 8; c++) exp_q.push_back({2'b01, 3'(c), 11'h0, ds[c]});
    trig_accept <= 1'b1;
    repeat (8) @(posedge pclk);
    trig_accept <= 1'b0;
    for (int n = 0; n < 5000 && exp_q.size() != 0; n++) @(posedge pclk);
    chk("left_in_queue", exp_q.size(), 0);
    chk("status_seen", n_stat != 0, 1);
    apb(1'b1, `FEB_ADDR_GATE, 32'h00000a14);
    st <= 8'($urandom());
    ref_run <= 1'b1;
    repeat (2500) @(posedge pclk);
    rd("stat_lock", `FEB_ADDR_STAT, {16'h0001, 8'h01, st}, 1'b0);
    chk("gate_len", last_glen, 80);
    rd("errt_clear", `FEB_ADDR_ERRT, 32'h0, 1'b0);
    bad_pos <= 7'd50;
    repeat (1000) @(posedge pclk);
    bad_pos <= 7'd0;
    apb(1'b0, `FEB_ADDR_ERRT, 32'h0);
    chk("errt_set", rdata != 0, 1);
    chk("errt_pos", rdata[6:0], 7'd50);
    end_sim();
  end
endmodule // photosensor_frontend_readout_bench
